/* File: rtl/bot_pkg.sv */
// Purpose: Constants for the blanking output timing block
// Assumes: Registers reached by 8-bit sub-address over the control port
// Notes:   Core clock is twice the pixel rate; one pixel per two edges
//
// What this block does
// RQ1 - Start of line blank is 10 bits: low register plus two high bits.
// RQ2 - At start count each line, raise blank and stop taking pixels.
// RQ3 - Line sync leading edge counts as 020 hex for start compare.
// RQ4 - Eight-bit end value; at that count, drop blank, take pixels again.
// RQ5 - Line sync leading edge counts as zero for the end compare.
// RQ6 - Position registers act only while the blank pin is an output.
// RQ7 - Start of frame blank is 9 bits: low register plus one high bit.
// RQ8 - Odd field: at line n stop taking pixels and blank the video.
// RQ9 - Even field: frame blank starts at n plus 262 or plus 313.
// RQ10 - Line count is zero at frame sync leading edge of odd field.
// RQ11 - High bit of frame blank start is bit 0; other bits reserved.
// RQ12 - Eight-bit frame blank end line, with same even-field offset.
// RQ13 - Offset 262 for 525-line systems, 313 for 625-line systems.
// RQ14 - Source withholds pixels while blank is high, sends them after.
package bot_pkg;
    // ------------------------------------------------------------
    // Register sub-addresses
    // ------------------------------------------------------------
    localparam logic [7:0] BOT_HB_START_LO_A = 8'h20;
    localparam logic [7:0] BOT_HB_START_HI_A = 8'h21;
    localparam logic [7:0] BOT_HB_END_A = 8'h22;
    localparam logic [7:0] BOT_VB_START_LO_A = 8'h23;
    localparam logic [7:0] BOT_VB_START_HI_A = 8'h24;
    localparam logic [7:0] BOT_VB_END_A = 8'h25;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BOT_HB_START_LO_R = 8'h4a;
    localparam logic [1:0] BOT_HB_START_HI_R = 2'h3;
    localparam logic [7:0] BOT_HB_END_R = 8'h7a;
    localparam logic [7:0] BOT_VB_START_LO_R = 8'h03;
    localparam logic BOT_VB_START_HI_R = 1'b1;
    localparam logic [7:0] BOT_VB_END_R = 8'h13;
    // ------------------------------------------------------------
    // Field widths and count references
    // ------------------------------------------------------------
    localparam int BOT_HS_W = 10;
    localparam int BOT_HCNT_W = 12;
    localparam int BOT_LINE_W = 10;
    localparam int BOT_HI_HB_W = 2;
    localparam logic [11:0] BOT_HSTART_REF = 12'h020;
    localparam logic [11:0] BOT_HEND_REF = 12'h000;
    localparam logic [9:0] BOT_LINE_REF = 10'h000;
    localparam logic [9:0] BOT_EVEN_OFS_525 = 10'd262;
    localparam logic [9:0] BOT_EVEN_OFS_625 = 10'd313;
endpackage : bot_pkg

/* File: rtl/bot_blank_timing.sv */
// Purpose: Horizontal and vertical blank output timing
// Assumes: Sync pins are asynchronous; config inputs are core-clock logic
// Notes:   Blank is only driven while the pin is configured as an output
module bot_blank_timing (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Control port register access
    input wire logic reg_we_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Configuration
    input wire logic blank_is_output_i,
    input wire logic std_625_i,
    // Sync pins from the source
    input wire logic hsync_i,
    input wire logic vsync_i,
    input wire logic field_odd_i,
    // Blank pin and pixel intake
    output logic blank_o,
    output logic blank_oe_n_o,
    output logic pixel_accept_o
);
    import bot_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic line_hit(input logic [9:0] line,
                                      input logic [9:0] n,
                                      input logic s625);
        logic [9:0] ofs;
        // RQ13 offset per system
        ofs = s625 ? BOT_EVEN_OFS_625 : BOT_EVEN_OFS_525;
        line_hit = (line == n) || (line == n + ofs);
    endfunction : line_hit

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] hb_start_lo_ff, nxt_hb_start_lo;
    logic [1:0] hb_start_hi_ff, nxt_hb_start_hi;
    logic [7:0] hb_end_ff, nxt_hb_end;
    logic [7:0] vb_start_lo_ff, nxt_vb_start_lo;
    logic vb_start_hi_ff, nxt_vb_start_hi;
    logic [7:0] vb_end_ff, nxt_vb_end;
    logic [7:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_hb_start_lo = hb_start_lo_ff;
        nxt_hb_start_hi = hb_start_hi_ff;
        nxt_hb_end = hb_end_ff;
        nxt_vb_start_lo = vb_start_lo_ff;
        nxt_vb_start_hi = vb_start_hi_ff;
        nxt_vb_end = vb_end_ff;
        if (reg_we_i) begin
            case (reg_addr_i)
                BOT_HB_START_LO_A: nxt_hb_start_lo = reg_wdata_i;
                // RQ1 high bits
                BOT_HB_START_HI_A:
                    nxt_hb_start_hi = reg_wdata_i[BOT_HI_HB_W-1:0];
                BOT_HB_END_A: nxt_hb_end = reg_wdata_i;
                BOT_VB_START_LO_A: nxt_vb_start_lo = reg_wdata_i;
                // RQ11 bit zero only
                BOT_VB_START_HI_A: nxt_vb_start_hi = reg_wdata_i[0];
                BOT_VB_END_A: nxt_vb_end = reg_wdata_i;
                default: ;
            endcase
        end
        // Reserved bits read back as zero
        case (reg_addr_i)
            BOT_HB_START_LO_A: nxt_rdata = hb_start_lo_ff;
            BOT_HB_START_HI_A: nxt_rdata = {6'h00, hb_start_hi_ff};
            BOT_HB_END_A: nxt_rdata = hb_end_ff;
            BOT_VB_START_LO_A: nxt_rdata = vb_start_lo_ff;
            BOT_VB_START_HI_A: nxt_rdata = {7'h00, vb_start_hi_ff};
            BOT_VB_END_A: nxt_rdata = vb_end_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            hb_start_lo_ff <= BOT_HB_START_LO_R;
            hb_start_hi_ff <= BOT_HB_START_HI_R;
            hb_end_ff <= BOT_HB_END_R;
            vb_start_lo_ff <= BOT_VB_START_LO_R;
            vb_start_hi_ff <= BOT_VB_START_HI_R;
            vb_end_ff <= BOT_VB_END_R;
            rdata_ff <= 8'h00;
        end else begin
            hb_start_lo_ff <= nxt_hb_start_lo;
            hb_start_hi_ff <= nxt_hb_start_hi;
            hb_end_ff <= nxt_hb_end;
            vb_start_lo_ff <= nxt_vb_start_lo;
            vb_start_hi_ff <= nxt_vb_start_hi;
            vb_end_ff <= nxt_vb_end;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // RQ1 cascade start
    logic [BOT_HS_W-1:0] hb_start;
    assign hb_start = {hb_start_hi_ff, hb_start_lo_ff};
    // RQ7 cascade start
    logic [8:0] vb_start;
    assign vb_start = {vb_start_hi_ff, vb_start_lo_ff};

    // ------------------------------------------------------------
    // Sync pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] hs_meta_ff, vs_meta_ff, fo_meta_ff;
    logic hs_old_ff, vs_old_ff;
    logic hs_rise, vs_rise;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            hs_meta_ff <= 3'h0;
            vs_meta_ff <= 3'h0;
            fo_meta_ff <= 3'h0;
        end else begin
            hs_meta_ff <= {hs_meta_ff[1:0], hsync_i};
            vs_meta_ff <= {vs_meta_ff[1:0], vsync_i};
            fo_meta_ff <= {fo_meta_ff[1:0], field_odd_i};
        end
    end
    // Stage 1 feeds stage 2 only; edges look at stages 2 and 3
    assign hs_old_ff = hs_meta_ff[2];
    assign vs_old_ff = vs_meta_ff[2];
    assign hs_rise = hs_meta_ff[1] & ~hs_old_ff;
    assign vs_rise = vs_meta_ff[1] & ~vs_old_ff;

    // ------------------------------------------------------------
    // Counters and blank state
    // ------------------------------------------------------------
    logic phase_ff, nxt_phase;
    logic [BOT_HCNT_W-1:0] hcnt_ff, nxt_hcnt;
    logic [BOT_LINE_W-1:0] line_ff, nxt_line;
    logic hblank_ff, nxt_hblank;
    logic vblank_ff, nxt_vblank;
    logic tick, h_start_hit, h_end_hit, v_start_hit, v_end_hit;

    // Count advances once per pixel: every second core edge
    assign tick = phase_ff;
    // RQ3 start reference
    assign h_start_hit = (hcnt_ff + BOT_HSTART_REF)
                         == {2'b00, hb_start};
    // RQ5 end reference
    assign h_end_hit = (hcnt_ff + BOT_HEND_REF) == {4'h0, hb_end_ff};
    // RQ9 even offset
    assign v_start_hit = line_hit(line_ff, {1'b0, vb_start}, std_625_i);
    // RQ12 even offset
    assign v_end_hit = line_hit(line_ff, {2'b00, vb_end_ff}, std_625_i);

    always_comb begin
        nxt_phase = ~phase_ff;
        nxt_hcnt = tick ? hcnt_ff + 12'h001 : hcnt_ff;
        nxt_line = line_ff;
        nxt_hblank = hblank_ff;
        nxt_vblank = vblank_ff;
        if (hs_rise) begin
            // RQ5 zero at sync
            nxt_phase = 1'b0;
            nxt_hcnt = 12'h000;
            nxt_line = line_ff + 10'h001;
        end
        // RQ10 odd field zero
        if (vs_rise && fo_meta_ff[2]) begin
            nxt_line = BOT_LINE_REF;
        end
        // RQ2 start wins a tie
        if (tick && h_start_hit) begin
            nxt_hblank = 1'b1;
        // RQ4 end of blank
        end else if (tick && h_end_hit) begin
            nxt_hblank = 1'b0;
        end
        // RQ8 frame blank start
        if (v_start_hit) begin
            nxt_vblank = 1'b1;
        // RQ12 frame blank end
        end else if (v_end_hit) begin
            nxt_vblank = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            phase_ff <= 1'b0;
            hcnt_ff <= 12'h000;
            line_ff <= 10'h000;
            hblank_ff <= 1'b0;
            vblank_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            hcnt_ff <= nxt_hcnt;
            line_ff <= nxt_line;
            hblank_ff <= nxt_hblank;
            vblank_ff <= nxt_vblank;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // RQ6 only as output
    assign blank_o = blank_is_output_i & (hblank_ff | vblank_ff);
    assign blank_oe_n_o = ~blank_is_output_i;
    // RQ14 source paces on blank
    assign pixel_accept_o = ~blank_o;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    blank_gate_a: assert property (@(posedge core_clk_i) // RQ6
        disable iff (srst_i) !blank_is_output_i |-> !blank_o && blank_oe_n_o)
        else $error("blank driven while pin is an input");
    hstart_set_a: assert property (@(posedge core_clk_i) // RQ2
        disable iff (srst_i) tick && h_start_hit && blank_is_output_i
        |=> blank_o && !pixel_accept_o)
        else $error("blank not raised at line start count");
    hstart_ref_a: assert property (@(posedge core_clk_i) // RQ3
        disable iff (srst_i) tick && hcnt_ff == 12'h000
        && {2'b00, hb_start} == BOT_HSTART_REF
        |=> hblank_ff)
        else $error("start compare not referenced to 020");
    hend_clr_a: assert property (@(posedge core_clk_i) // RQ4
        disable iff (srst_i) tick && h_end_hit && !h_start_hit
        |=> !hblank_ff)
        else $error("blank not dropped at end count");
    hedge_zero_a: assert property (@(posedge core_clk_i) // RQ5
        disable iff (srst_i) hs_rise ##1 !hs_rise [*2]
        |-> hcnt_ff == 12'h000)
        else $error("line count not restarted at sync");
    hs_reg_a: assert property (@(posedge core_clk_i) // RQ1
        disable iff (srst_i) reg_we_i && reg_addr_i == BOT_HB_START_HI_A
        |=> hb_start[9:8] == $past(reg_wdata_i[1:0]))
        else $error("start high bits not stored");
    vs_reg_a: assert property (@(posedge core_clk_i) // RQ11
        disable iff (srst_i) reg_we_i && reg_addr_i == BOT_VB_START_HI_A
        |=> vb_start[8] == $past(reg_wdata_i[0])
            ##1 reg_rdata_o[7:1] == 7'h00
            || $past(reg_addr_i) != BOT_VB_START_HI_A)
        else $error("frame start high bit wrong");
    vstart_odd_a: assert property (@(posedge core_clk_i) // RQ8
        disable iff (srst_i) line_ff == {1'b0, vb_start} |=> vblank_ff)
        else $error("frame blank not started at line n");
    veven_ofs_a: assert property (@(posedge core_clk_i) // RQ13
        disable iff (srst_i)
        line_ff == {1'b0, vb_start}
        + (std_625_i ? BOT_EVEN_OFS_625 : BOT_EVEN_OFS_525)
        |=> vblank_ff)
        else $error("even field start offset wrong");
    vodd_zero_a: assert property (@(posedge core_clk_i) // RQ10
        disable iff (srst_i) vs_rise && fo_meta_ff[2] |=> line_ff == 10'h000)
        else $error("line count not zero at odd field sync");
    vend_clr_a: assert property (@(posedge core_clk_i) // RQ12
        disable iff (srst_i) v_end_hit && !v_start_hit |=> !vblank_ff)
        else $error("frame blank not ended at end line");
endmodule : bot_blank_timing

/* File: test/bot_video_src.sv */
// Purpose: Upstream pixel source model driving the sync pins
// Assumes: Syncs are driven just after a rising core clock edge
// Notes:   Pulse spacing is left to the caller's tasks
module bot_video_src (
    // Clock
    input wire logic core_clk_i,
    // Blank pin from the device
    input wire logic blank_i,
    // Sync pins and pixel qualifier towards the device
    output logic hsync_o,
    output logic vsync_o,
    output logic field_odd_o,
    output logic pix_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hsync_o = 1'b0;
        vsync_o = 1'b0;
        field_odd_o = 1'b0;
    end
    always_ff @(posedge core_clk_i) begin
        pix_valid_o <= ~blank_i;
    end
    task automatic pulse_h();
        @(posedge core_clk_i);
        hsync_o <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        hsync_o <= 1'b0;
    endtask : pulse_h
    // Field flag settles a cycle ahead so it is seen with the sync edge
    task automatic frame(input logic odd);
        @(posedge core_clk_i);
        field_odd_o <= odd;
        @(posedge core_clk_i);
        vsync_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        vsync_o <= 1'b0;
    endtask : frame
endmodule : bot_video_src

/* File: test/bot_blank_timing_test.sv */
// Purpose: Self-checking bench for the blanking output timing block
// Assumes: Blank edges land one core cycle after the count hits
// Notes:   Edge times are checked in a small window of core cycles
module bot_blank_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bot_pkg::*;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_we_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic blank_is_output_i = 1'b1;
    logic std_625_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic blank_o, blank_oe_n_o, pixel_accept_o;
    logic hsync_i, vsync_i, field_odd_i, pix_valid;
    int err_count = 0;
    int check_count = 0;
    int cyc;
    initial forever #5 core_clk_i = ~core_clk_i;
    bot_blank_timing i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .blank_is_output_i(blank_is_output_i), .std_625_i(std_625_i),
        .hsync_i(hsync_i), .vsync_i(vsync_i), .field_odd_i(field_odd_i),
        .blank_o(blank_o), .blank_oe_n_o(blank_oe_n_o),
        .pixel_accept_o(pixel_accept_o));
    bot_video_src i_src (.core_clk_i(core_clk_i), .blank_i(blank_o),
        .hsync_o(hsync_i), .vsync_o(vsync_i), .field_odd_o(field_odd_i),
        .pix_valid_o(pix_valid));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("rdata", {2'b00, e}, {2'b00, reg_rdata_o});
    endtask : rd
    // Counts from the end of the sync pulse until blank takes lvl
    task automatic hwait(input logic lvl, input int lo, input int hi);
        while (blank_o !== lvl && cyc < 3000) begin
            @(posedge core_clk_i);
            #1;
            cyc++;
        end
        if (cyc >= 3000) begin
            err_count++;
            final_report();
        end
        chk("hblank edge in window", 10'h1, {9'h0, cyc >= lo && cyc <= hi});
    endtask : hwait
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] rst [7];
        logic oe, win;
        int ofs;
        rst = '{BOT_HB_START_LO_R, {6'h0, BOT_HB_START_HI_R},
            BOT_HB_END_R, BOT_VB_START_LO_R, {7'h0, BOT_VB_START_HI_R},
            BOT_VB_END_R, 8'h00};
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 7; i++) rd(8'h20 + 8'(i), rst[i]);
        wr(8'h21, 8'hff);
        rd(8'h21, 8'h03);
        wr(8'h24, 8'hff);
        rd(8'h24, 8'h01);
        wr(8'h26, 8'h5a);
        rd(8'h26, 8'h00);
        // Line blank parked out of reach so blank follows frame blank only
        wr(8'h20, 8'hff);
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h05);
        wr(8'h24, 8'h00);
        wr(8'h25, 8'h08);
        rd(8'h25, 8'h08);
        for (int s = 0; s < 2; s++) begin
            std_625_i <= s[0];
            ofs = (s == 1) ? 313 : 262;
            i_src.frame(1'b1);
            for (int k = 1; k <= ofs + 10; k++) begin
                i_src.pulse_h();
                oe = (k != 6);
                blank_is_output_i <= oe;
                repeat (8) @(posedge core_clk_i);
                #1;
                win = (k >= 5 && k < 8) || (k >= 5 + ofs && k < 8 + ofs);
                chk("blank", {9'h0, oe & win}, {9'h0, blank_o});
                chk("accept", {9'h0, ~(oe & win)}, {9'h0, pixel_accept_o});
                chk("pix_valid", {9'h0, ~(oe & win)}, {9'h0, pix_valid});
                chk("oe_n", {9'h0, ~oe}, {9'h0, blank_oe_n_o});
            end
        end
        wr(8'h20, 8'h30);
        wr(8'h21, 8'h00);
        wr(8'h22, 8'h28);
        i_src.pulse_h();
        cyc = 0;
        hwait(1'b1, 32, 38);
        hwait(1'b0, 80, 86);
        wr(8'h21, 8'h01);
        wr(8'h22, 8'h20);
        i_src.pulse_h();
        cyc = 0;
        hwait(1'b1, 544, 550);
        i_src.pulse_h();
        cyc = 0;
        hwait(1'b0, 64, 70);
        // Start at 020 hits on the first pixel after the sync edge
        wr(8'h20, 8'h20);
        wr(8'h21, 8'h00);
        wr(8'h22, 8'h10);
        i_src.pulse_h();
        cyc = 0;
        hwait(1'b1, 1, 5);
        hwait(1'b0, 32, 38);
        final_report();
    end
endmodule : bot_blank_timing_test
